/* File: verilog/fcm_top.v */
// FLL clock-mode control: AHB-Lite registers, seven-state mode machine, clock gating.
// Assumes reference and FLL clocks arrive as one-cycle tick pulses on mclk.
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "fcm_regs.vh"
module fcm_top #(
    parameter OSC_INIT_CYCLES = `FCM_OSC_INIT_CYCLES,
    parameter PER_W = 16
) (
    input wire mclk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire int_ref_tick,
    input wire ext_ref_tick,
    input wire fll_tick,
    input wire debug_mode_active,
    input wire stop_mode,
    output reg main_clock_output,
    output reg locked_debug_clock,
    output reg internal_reference_output,
    output reg external_reference_output,
    output reg fll_ref_pulse,
    output reg fll_enable,
    output reg [10:0] fll_multiplier,
    output reg int_ref_enable,
    output reg ext_ref_enable,
    output reg fine_period_adjust
);

// ----------------------------------------
// States, one-hot
// ----------------------------------------
localparam [6:0] ST_FEI = 7'h01;
localparam [6:0] ST_FEE = 7'h02;
localparam [6:0] ST_FBI = 7'h04;
localparam [6:0] ST_BYPASS_INTERNAL_LOW_POWER = 7'h08;
localparam [6:0] ST_FBE = 7'h10;
localparam [6:0] ST_BYPASS_EXTERNAL_LOW_POWER = 7'h20;
localparam [6:0] ST_STOP = 7'h40;
localparam integer PER_MIN_I = `FCM_PER_MIN;
localparam integer PER_MAX_I = `FCM_PER_MAX;
localparam [PER_W-1:0] PER_MIN = PER_MIN_I[PER_W-1:0];
localparam [PER_W-1:0] PER_MAX = PER_MAX_I[PER_W-1:0];

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] ctrl1_reg;
reg [7:0] ctrl2_reg;
reg wr_pend_reg;
reg [`FCM_ADDR_W-1:0] wr_addr_reg;
reg [6:0] state_reg;
reg [6:0] state_next;
reg [6:0] saved_reg;
reg [6:0] div_cnt_reg;
reg [PER_W-1:0] per_cnt_reg;
reg in_range_reg;
reg [7:0] rd_data;

wire [1:0] clock_source_select = ctrl1_reg[`FCM_C1_SRC_HI:`FCM_C1_SRC_LO];
wire [2:0] reference_divider = ctrl1_reg[`FCM_C1_DIV_HI:`FCM_C1_DIV_LO];
wire reference_select = ctrl1_reg[`FCM_C1_REFSEL];
wire int_ref_output_enable = ctrl1_reg[`FCM_C1_INT_REF_OUTPUT_ENABLE];
wire int_ref_stop_keep = ctrl1_reg[`FCM_C1_IRSTOP];
wire low_power_select = ctrl2_reg[`FCM_C2_LP];
wire oscillator_select = ctrl2_reg[`FCM_C2_OSCSEL];
wire ext_ref_output_enable = ctrl2_reg[`FCM_C2_EXT_REF_OUTPUT_ENABLE];
wire ext_ref_stop_keep = ctrl2_reg[`FCM_C2_ERSTOP];

wire addr_phase = hsel && htrans[1] && hready;
wire [`FCM_ADDR_W-1:0] addr_lo = haddr[`FCM_ADDR_W-1:0];

// ----------------------------------------
// Mode decode helpers
// ----------------------------------------
wire in_stop = (state_reg == ST_STOP);
wire mode_fll = (state_reg == ST_FEI) || (state_reg == ST_FEE);
wire mode_int = (state_reg == ST_FBI) || (state_reg == ST_BYPASS_INTERNAL_LOW_POWER);
wire mode_ext = (state_reg == ST_FBE) || (state_reg == ST_BYPASS_EXTERNAL_LOW_POWER);
wire uses_int = (state_reg == ST_FEI) || mode_int;
wire uses_ext = (state_reg == ST_FEE) || mode_ext;
wire fll_on = (state_reg == ST_FEI) || (state_reg == ST_FEE) ||
    (state_reg == ST_FBI) || (state_reg == ST_FBE);
wire [1:0] applied_src = mode_int ? `FCM_SRC_INT : (mode_ext ? `FCM_SRC_EXT : `FCM_SRC_FLL);
wire ref_tick = reference_select ? int_ref_tick : ext_ref_tick;
wire [6:0] div_mask = (7'h01 << reference_divider) - 7'h01;
wire div_pulse = ref_tick && ((div_cnt_reg & div_mask) == div_mask);
wire osc_ready;
wire [2:0] status_sync;

// ----------------------------------------
// Submodules
// ----------------------------------------
// Status follows the applied mode only after two flops, never the write itself
fcm_sync #(
    .WIDTH(3)
) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({applied_src, uses_int}),
    .sync_out(status_sync)
);

fcm_osc_init #(
    .INIT_CYCLES(OSC_INIT_CYCLES)
) u_osc (
    .mclk(mclk),
    .rst(rst),
    .ext_ref_tick(ext_ref_tick),
    .requested(ext_ref_output_enable || uses_ext),
    .osc_sel(oscillator_select),
    .ext_en(ext_ref_output_enable),
    .osc_ready(osc_ready)
);

// ----------------------------------------
// Bus slave: zero wait states, always OKAY
// ----------------------------------------
always @* begin
    rd_data = 8'h00;
    case (addr_lo)
        `FCM_ADDR_CTRL1: begin
            rd_data = ctrl1_reg;
        end
        `FCM_ADDR_CTRL2: begin
            rd_data = ctrl2_reg;
        end
        `FCM_ADDR_STAT: begin
            // Reserved upper bits read as zero
            rd_data[`FCM_ST_REFST] = status_sync[0];
            rd_data[`FCM_ST_MODE_HI:`FCM_ST_MODE_LO] = status_sync[2:1];
            rd_data[`FCM_ST_OSCINIT] = osc_ready;
            rd_data[`FCM_ST_FINE_PERIOD_ADJUST] = fine_period_adjust;
        end
        default: begin
            rd_data = 8'h00;
        end
    endcase
end

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= {`FCM_ADDR_W{1'b0}};
        ctrl1_reg <= `FCM_C1_RESET;
        ctrl2_reg <= `FCM_C2_RESET;
        fine_period_adjust <= `FCM_ST_FINE_PERIOD_ADJUST_RESET;
    end else begin
        wr_pend_reg <= addr_phase && hwrite;
        if (addr_phase) begin
            wr_addr_reg <= addr_lo;
        end
        if (addr_phase && !hwrite) begin
            hrdata <= {24'h000000, rd_data};
        end
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `FCM_ADDR_CTRL1: begin
                    ctrl1_reg <= hwdata[7:0];
                end
                `FCM_ADDR_CTRL2: begin
                    ctrl2_reg <= hwdata[7:0] & `FCM_C2_MASK;
                end
                `FCM_ADDR_STAT: begin
                    // Only the trim bit is writable; status bits ignore writes
                    fine_period_adjust <= hwdata[`FCM_ST_FINE_PERIOD_ADJUST];
                end
                default: begin
                    fine_period_adjust <= fine_period_adjust;
                end
            endcase
        end
    end
end

// ----------------------------------------
// Reference divider and range check
// ----------------------------------------
// Period of the divided reference measured in mclk cycles; saturates when slow
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        div_cnt_reg <= 7'h00;
        per_cnt_reg <= {PER_W{1'b0}};
        in_range_reg <= 1'b0;
    end else begin
        if (ref_tick) begin
            div_cnt_reg <= div_pulse ? 7'h00 : div_cnt_reg + 7'h01;
        end
        if (div_pulse) begin
            in_range_reg <= (per_cnt_reg >= PER_MIN) && (per_cnt_reg <= PER_MAX);
            per_cnt_reg <= {PER_W{1'b0}};
        end else if (per_cnt_reg != {PER_W{1'b1}}) begin
            per_cnt_reg <= per_cnt_reg + {{(PER_W-1){1'b0}}, 1'b1};
        end
    end
end

// ----------------------------------------
// Mode state machine
// ----------------------------------------
// A request that cannot be met (wrong reference, out of range) keeps the old mode
always @* begin
    state_next = state_reg;
    case (clock_source_select)
        `FCM_SRC_INT: begin
            if (reference_select) begin
                state_next = (debug_mode_active || !low_power_select) ? ST_FBI : ST_BYPASS_INTERNAL_LOW_POWER;
            end
        end
        `FCM_SRC_EXT: begin
            if (!reference_select) begin
                state_next = (debug_mode_active || !low_power_select) ? ST_FBE : ST_BYPASS_EXTERNAL_LOW_POWER;
            end
        end
        default: begin
            // Reserved select behaves as FLL output
            if (in_range_reg) begin
                state_next = reference_select ? ST_FEI : ST_FEE;
            end
        end
    endcase
end

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        state_reg <= ST_FEI;
        saved_reg <= ST_FEI;
    end else begin
        case (state_reg)
            ST_FEI, ST_FEE, ST_FBI, ST_BYPASS_INTERNAL_LOW_POWER, ST_FBE, ST_BYPASS_EXTERNAL_LOW_POWER: begin
                if (stop_mode) begin
                    saved_reg <= state_reg;
                    state_reg <= ST_STOP;
                end else begin
                    state_reg <= state_next;
                end
            end
            ST_STOP: begin
                if (!stop_mode) begin
                    state_reg <= saved_reg;
                end
            end
            default: begin
                state_reg <= ST_FEI;
            end
        endcase
    end
end

// ----------------------------------------
// Clock outputs, all registered
// ----------------------------------------
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        main_clock_output <= 1'b0;
        locked_debug_clock <= 1'b0;
        internal_reference_output <= 1'b0;
        external_reference_output <= 1'b0;
        fll_ref_pulse <= 1'b0;
        fll_enable <= 1'b0;
        fll_multiplier <= 11'h000;
        int_ref_enable <= 1'b0;
        ext_ref_enable <= 1'b0;
    end else begin
        // Everything static in stop except the kept references
        main_clock_output <= !in_stop && ((mode_fll && fll_tick) || (mode_int && int_ref_tick) ||
            (mode_ext && ext_ref_tick));
        locked_debug_clock <= fll_on && fll_tick;
        fll_enable <= fll_on;
        fll_ref_pulse <= fll_on && div_pulse;
        fll_multiplier <= fll_on ? `FCM_FLL_FACTOR : 11'h000;
        if (in_stop) begin
            internal_reference_output <= int_ref_output_enable && int_ref_stop_keep && int_ref_tick;
            external_reference_output <= ext_ref_output_enable && ext_ref_stop_keep && ext_ref_tick;
            int_ref_enable <= int_ref_output_enable && int_ref_stop_keep;
            ext_ref_enable <= ext_ref_output_enable && ext_ref_stop_keep;
        end else begin
            internal_reference_output <= int_ref_output_enable && int_ref_tick;
            external_reference_output <= ext_ref_output_enable && ext_ref_tick;
            int_ref_enable <= int_ref_output_enable || uses_int;
            ext_ref_enable <= ext_ref_output_enable || uses_ext;
        end
    end
end

endmodule // fcm_top

/* File: pkg/fcm_regs.vh */
// Constants of the FLL clock-mode control block: register map, fields, resets, timing.
// Assumes inclusion by the design files of the block that use its constants; definitions only.
`ifndef FCM_REGS_VH
`define FCM_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define FCM_ADDR_CTRL1 8'h00
`define FCM_ADDR_CTRL2 8'h04
`define FCM_ADDR_STAT 8'h08
`define FCM_ADDR_W 8

// ----------------------------------------
// Control 1 fields and reset
// ----------------------------------------
`define FCM_C1_SRC_HI 7
`define FCM_C1_SRC_LO 6
`define FCM_C1_DIV_HI 5
`define FCM_C1_DIV_LO 3
`define FCM_C1_REFSEL 2
`define FCM_C1_INT_REF_OUTPUT_ENABLE 1
`define FCM_C1_IRSTOP 0
`define FCM_C1_RESET 8'h04

// ----------------------------------------
// Control 2 fields and reset
// ----------------------------------------
`define FCM_C2_LP 3
`define FCM_C2_OSCSEL 2
`define FCM_C2_EXT_REF_OUTPUT_ENABLE 1
`define FCM_C2_ERSTOP 0
`define FCM_C2_MASK 8'h0F
`define FCM_C2_RESET 8'h00

// ----------------------------------------
// Status fields and reset
// ----------------------------------------
`define FCM_ST_REFST 4
`define FCM_ST_MODE_HI 3
`define FCM_ST_MODE_LO 2
`define FCM_ST_OSCINIT 1
`define FCM_ST_FINE_PERIOD_ADJUST 0
`define FCM_ST_FINE_PERIOD_ADJUST_RESET 1'b0

// ----------------------------------------
// Clock mode codes, shared by select and status
// ----------------------------------------
`define FCM_SRC_FLL 2'h0
`define FCM_SRC_INT 2'h1
`define FCM_SRC_EXT 2'h2
`define FCM_SRC_RSV 2'h3

// ----------------------------------------
// Timing: divided reference window and FLL factor
// ----------------------------------------
`define FCM_CLK_HZ 10000000
`define FCM_REF_MIN_HZ 31250
`define FCM_REF_MAX_NUM 390625
`define FCM_REF_MAX_DEN 10
`define FCM_PER_MAX (`FCM_CLK_HZ / `FCM_REF_MIN_HZ)
`define FCM_PER_MIN ((`FCM_CLK_HZ * `FCM_REF_MAX_DEN + `FCM_REF_MAX_NUM - 1) / `FCM_REF_MAX_NUM)
`define FCM_FLL_FACTOR 11'h400
`define FCM_OSC_INIT_CYCLES 16

`endif

/* File: verilog/fcm_sync.v */
// Two-flop synchroniser for the status fields that follow the applied clock mode.
// Assumes a single clock; the input may change in any cycle.
`timescale 1ns/10ps
module fcm_sync #(
    parameter WIDTH = 3
) (
    input wire mclk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

// First stage feeds only the second stage
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        meta_reg <= {WIDTH{1'b0}};
        sync_reg <= {WIDTH{1'b0}};
    end else begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule // fcm_sync

/* File: verilog/fcm_osc_init.v */
// External oscillator start-up tracker: counts reference edges after a request.
// Assumes ext_ref_tick is a one-cycle pulse per external reference period.
`timescale 1ns/10ps
`include "fcm_regs.vh"
module fcm_osc_init #(
    parameter INIT_CYCLES = `FCM_OSC_INIT_CYCLES,
    parameter CNT_W = 12
) (
    input wire mclk,
    input wire rst,
    input wire ext_ref_tick,
    input wire requested,
    input wire osc_sel,
    input wire ext_en,
    output wire osc_ready
);

localparam integer LAST_I = INIT_CYCLES - 1;
localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];

reg [CNT_W-1:0] cnt_reg;
reg ready_reg;

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        cnt_reg <= {CNT_W{1'b0}};
        ready_reg <= 1'b0;
    end else begin
        if (!ext_en || !osc_sel) begin
            // Only these two bits release the flag
            ready_reg <= 1'b0;
            cnt_reg <= {CNT_W{1'b0}};
        end else if (requested && !ready_reg && ext_ref_tick) begin
            if (cnt_reg == LAST) begin
                ready_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
end

assign osc_ready = ready_reg;

endmodule // fcm_osc_init

/* File: test/fcm_properties.sv */
// Checker of the FLL clock-mode control block: output timing against tick inputs.
// Assumes a bind to fcm_top; all outputs are registered one cycle behind inputs.
`timescale 1ns/10ps
module fcm_properties (
    input logic mclk,
    input logic rst,
    input logic int_ref_tick,
    input logic ext_ref_tick,
    input logic fll_tick,
    input logic stop_mode,
    input logic main_clock_output,
    input logic locked_debug_clock,
    input logic internal_reference_output,
    input logic external_reference_output,
    input logic fll_ref_pulse,
    input logic fll_enable,
    input logic [10:0] fll_multiplier
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Three cycles of stop cover the state change and the output register
    AST_STOP_STATIC: assert property (stop_mode [*3] |-> !main_clock_output && !locked_debug_clock)
        else $error("clock output toggles in stop");
    AST_INT_SRC: assert property (internal_reference_output |-> $past(int_ref_tick))
        else $error("internal reference output without a tick");
    AST_EXT_SRC: assert property (external_reference_output |-> $past(ext_ref_tick))
        else $error("external reference output without a tick");
    AST_FLL_FACTOR: assert property (fll_multiplier == (fll_enable ? 11'h400 : 11'h000))
        else $error("multiplier does not follow the loop enable");
    AST_DBG_CLK: assert property (locked_debug_clock |-> fll_enable && $past(fll_tick))
        else $error("debug clock while the loop is off");
    AST_MAIN_SRC: assert property (main_clock_output |-> $past(fll_tick) || $past(int_ref_tick) || $past(ext_ref_tick))
        else $error("main output without a source tick");
    AST_RESET_FEI: assert property ($fell(rst) |-> ##[0:3] fll_enable)
        else $error("loop not engaged after reset");
    AST_REF_PULSE: assert property (fll_ref_pulse |-> fll_enable || $past(fll_enable))
        else $error("divided reference while the loop is off");

    COV_STOP_KEEP: cover property (stop_mode [*3] ##0 internal_reference_output);
    COV_FLL_OFF: cover property ($fell(fll_enable));
    COV_BYPASS: cover property (main_clock_output && !fll_enable);
endmodule // fcm_properties

/* File: test/tb_fcm_top.sv */
// Testbench of the FLL clock-mode control block: bus tasks, mode and stop tests.
// Assumes the checker file compiles first; reference ticks are made here.
`timescale 1ns/10ps
`include "fcm_regs.vh"
module tb_fcm_top;
    logic mclk, rst, hsel, hwrite, int_ref_tick, ext_ref_tick, fll_tick, debug_mode_active, stop_mode;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire [31:0] hrdata;
    wire hready, hresp, main_clock_output, locked_debug_clock, internal_reference_output;
    wire external_reference_output, fll_ref_pulse, fll_enable, int_ref_enable, ext_ref_enable, fine_period_adjust;
    wire [10:0] fll_multiplier;
    int n_fail = 0, samples_checked = 0, ci = 0, ce = 0, n_int = 0, n_ext = 0, n_main = 0, n_dbg = 0, n_snap = 0;

    fcm_top #(.OSC_INIT_CYCLES(2)) dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .int_ref_tick(int_ref_tick), .ext_ref_tick(ext_ref_tick), .fll_tick(fll_tick),
        .debug_mode_active(debug_mode_active), .stop_mode(stop_mode), .main_clock_output(main_clock_output),
        .locked_debug_clock(locked_debug_clock), .internal_reference_output(internal_reference_output),
        .external_reference_output(external_reference_output), .fll_ref_pulse(fll_ref_pulse),
        .fll_enable(fll_enable), .fll_multiplier(fll_multiplier), .int_ref_enable(int_ref_enable),
        .ext_ref_enable(ext_ref_enable), .fine_period_adjust(fine_period_adjust));

    // ----------------------------------------
    // Clock, reference ticks, output counters
    // ----------------------------------------
    always #50 mclk = ~mclk;
    // Periods 300 and 36 land in the 256..320 window at divider codes 0 and 3
    always @(posedge mclk) begin
        ci <= (ci == 299) ? 0 : ci + 1;
        ce <= (ce == 35) ? 0 : ce + 1;
        int_ref_tick <= (ci == 0);
        ext_ref_tick <= (ce == 0);
        fll_tick <= ~fll_tick;
        n_int <= n_int + internal_reference_output;
        n_ext <= n_ext + external_reference_output;
        n_main <= n_main + main_clock_output;
        n_dbg <= n_dbg + locked_debug_clock;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        q = hrdata;
    endtask
    // Status follows a mode change only after synchronisation, so writes leave time to settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        repeat (8) @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic pin(input logic v, input logic exp);
        chk({31'h0, v}, {31'h0, exp});
    endtask
    task automatic stop_run(input logic [7:0] c1, input logic [7:0] c2, input logic [31:0] keep);
        int si, se, sm, sd;
        wr(`FCM_ADDR_CTRL1, c1);
        wr(`FCM_ADDR_CTRL2, c2);
        stop_mode <= 1'b1;
        repeat (5) @(posedge mclk);
        si = n_int;
        se = n_ext;
        sm = n_main;
        sd = n_dbg;
        repeat (1000) @(posedge mclk);
        chk({31'h0, n_int != si}, keep);
        chk({31'h0, n_ext != se}, keep);
        chk({31'h0, (n_main != sm) || (n_dbg != sd)}, 32'h0);
        chk({31'h0, int_ref_enable}, keep);
        chk({31'h0, ext_ref_enable}, keep);
        stop_mode <= 1'b0;
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        final_report();
    end
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        int_ref_tick = 1'b0;
        ext_ref_tick = 1'b0;
        fll_tick = 1'b0;
        debug_mode_active = 1'b0;
        stop_mode = 1'b0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(`FCM_ADDR_CTRL1, 32'h04);
        rd(`FCM_ADDR_CTRL2, 32'h00);
        rd(`FCM_ADDR_STAT, 32'h10);
        pin(fll_enable, 1'b1);
        chk({21'h0, fll_multiplier}, 32'h400);
        pin(int_ref_enable, 1'b1);
        chk({31'h0, hresp}, 32'h0);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 32'h0);
        $display("test reset done");
        wr(`FCM_ADDR_STAT, 8'hFF);
        rd(`FCM_ADDR_STAT, 32'h11);
        pin(fine_period_adjust, 1'b1);
        wr(`FCM_ADDR_STAT, 8'h00);
        rd(`FCM_ADDR_STAT, 32'h10);
        pin(fine_period_adjust, 1'b0);
        $display("test trim done");
        wr(`FCM_ADDR_CTRL1, 8'h46);
        rd(`FCM_ADDR_STAT, 32'h14);
        pin(fll_enable, 1'b1);
        wr(`FCM_ADDR_CTRL2, 8'h08);
        pin(fll_enable, 1'b0);
        n_snap = n_dbg;
        rd(`FCM_ADDR_STAT, 32'h14);
        chk(n_dbg, n_snap);
        debug_mode_active <= 1'b1;
        repeat (6) @(posedge mclk);
        pin(fll_enable, 1'b1);
        chk({31'h0, n_dbg != n_snap}, 32'h1);
        debug_mode_active <= 1'b0;
        $display("test internal bypass done");
        wr(`FCM_ADDR_CTRL2, 8'h06);
        repeat (200) @(posedge mclk);
        rd(`FCM_ADDR_STAT, 32'h16);
        wr(`FCM_ADDR_CTRL1, 8'h80);
        rd(`FCM_ADDR_STAT, 32'h0A);
        pin(fll_enable, 1'b1);
        wr(`FCM_ADDR_CTRL2, 8'h0E);
        pin(fll_enable, 1'b0);
        wr(`FCM_ADDR_CTRL1, 8'h18);
        repeat (1000) @(posedge mclk);
        rd(`FCM_ADDR_STAT, 32'h02);
        pin(fll_enable, 1'b1);
        wr(`FCM_ADDR_CTRL2, 8'h0C);
        rd(`FCM_ADDR_STAT, 32'h00);
        pin(ext_ref_enable, 1'b1);
        $display("test external done");
        wr(`FCM_ADDR_CTRL1, 8'h04);
        repeat (1000) @(posedge mclk);
        rd(`FCM_ADDR_STAT, 32'h10);
        $display("test engaged internal done");
        stop_run(8'h07, 8'h03, 32'h1);
        stop_run(8'h06, 8'h02, 32'h0);
        $display("test stop done");
        final_report();
    end
endmodule // tb_fcm_top

bind fcm_top fcm_properties u_props (.mclk(mclk), .rst(rst), .int_ref_tick(int_ref_tick),
    .ext_ref_tick(ext_ref_tick), .fll_tick(fll_tick), .stop_mode(stop_mode), .main_clock_output(main_clock_output),
    .locked_debug_clock(locked_debug_clock), .internal_reference_output(internal_reference_output),
    .external_reference_output(external_reference_output), .fll_ref_pulse(fll_ref_pulse),
    .fll_enable(fll_enable), .fll_multiplier(fll_multiplier));
